// ===== asfr_fifo.sv
`timescale 1ns/1ns
module asfr_fifo #(
  parameter int W  = 8,
  parameter int D  = 32,
  parameter int AW = 5
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } asfr_fifo_st_t;
  asfr_fifo_st_t s_q, s_d;
  logic [W-1:0] mem [D];
  logic push, pop;
  assign in_ready  = (s_q.wp - s_q.rp) != (AW+1)'(D);
  assign out_valid = s_q.wp != s_q.rp;
  assign out_data  = mem[s_q.rp[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop) s_d.rp = s_q.rp + 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) s_q <= '0;
    else s_q <= s_d;
  end
  always_ff @(posedge clk) begin
    if (push) mem[s_q.wp[AW-1:0]] <= in_data;
  end
endmodule

// ===== asfr_host_model.sv
`timescale 1ns/1ns
module asfr_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // byte stream from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // pacing: 0 prompt, 1 every other cycle, 2 stalled
  input  wire logic [1:0] pace
);
  logic [7:0] got[$];
  logic       ph_q;
  // bytes are only collected; no field is acted on or answered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
      end
    end
  end
  assign tx_ready = ~rst & ((pace == 2'h0) | ((pace == 2'h1) & ph_q));
endmodule

// ===== asfr_pkg.sv
package asfr_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DELIM = 7'h02,
    ST_LEN_HI = 7'h04,
    ST_LEN_LO = 7'h08,
    ST_HDR = 7'h10,
    ST_BODY = 7'h20,
    ST_SUM = 7'h40
  } asfr_state_t;
  typedef enum logic [1:0] {
    K_SEND = 2'h0,
    K_DSTS = 2'h1,
    K_FERR = 2'h2,
    K_DREQ = 2'h3
  } asfr_kind_t;
endpackage

// ===== asfr_regs.svh
// How it works
// - a send-data request with nonzero frame id yields one 0xb8 response frame
// - 0xb8 frame holds type at byte 3, frame id at 4, status at 5
// - send status codes 00 ok, 01 bad, 02 none, 03 service fail, 40 unknown
// - each valid remote device request is forwarded as a 0xb9 frame
// - 0xb9 holds request id, transport, flags, target length, target, payload
// - a host device response 0x2a yields one 0xba status frame
// - 0xba frame echoes the host response frame id at byte 4
// - response status codes 00 ok, 20 cancelled, 21 timeout, 40 unknown
// - a bad inbound frame yields a 0xfe report with cause at byte 4; one arriving while a report is still pending is dropped
// - causes 02 bad type, 03 bad length, 04 checksum mismatch
// - causes 05 payload too big, 06 string entry too long
// - causes 07 wrong state, 08 request id mismatch
// - an error report may go out alongside the 0xba for the same response
`ifndef ASFR_REGS_SVH
`define ASFR_REGS_SVH
`define ASFR_DELIM      8'h7e
`define ASFR_T_SEND_RSP 8'hb8
`define ASFR_T_DEV_REQ  8'hb9
`define ASFR_T_DEV_STS  8'hba
`define ASFR_T_FERR     8'hfe
`define ASFR_T_SEND_REQ 8'h28
`define ASFR_T_DEV_RSP  8'h2a
`define ASFR_FIFO_DEPTH 32
`define ASFR_FIFO_AW    5
`endif

// ===== asfr_top.sv
`timescale 1ns/1ns
`include "asfr_regs.svh"
module asfr_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // send-data completion event
  input  wire logic       send_done,
  input  wire logic [7:0] send_fid,
  input  wire logic [7:0] send_status,
  // device-response status event
  input  wire logic       dsts_done,
  input  wire logic [7:0] dsts_fid,
  input  wire logic [7:0] dsts_status,
  // inbound frame error event
  input  wire logic       ferr_event,
  input  wire logic [7:0] ferr_cause,
  // remote device request header, then payload stream
  input  wire logic       dreq_start,
  input  wire logic [7:0] dreq_id,
  input  wire logic [7:0] dreq_transport,
  input  wire logic [7:0] dreq_flags,
  input  wire logic [7:0] dreq_tlen,
  input  wire logic [15:0] dreq_blen,
  input  wire logic       dreq_valid,
  input  wire logic [7:0] dreq_data,
  // events pending / payload byte taken
  output logic            evt_busy,
  output logic            dreq_ready,
  // byte stream to the serial link
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output logic [7:0]      tx_data
);
  typedef struct packed {
    asfr_pkg::asfr_state_t st;
    asfr_pkg::asfr_kind_t  kind;
    logic [7:0]  b3;
    logic [7:0]  b4;
    logic [7:0]  b5;
    logic [7:0]  b6;
    logic [7:0]  b7;
    logic [2:0]  hidx;
    logic [2:0]  hcnt;
    logic [15:0] blen;
    logic [15:0] len;
    logic [7:0]  sum;
    logic        p_send;
    logic [15:0] p_send_w;
    logic        p_dsts;
    logic [15:0] p_dsts_w;
    logic        p_ferr;
    logic [7:0]  p_ferr_c;
    logic        busy;
    logic        rdy;
    logic        fv;
    logic [7:0]  fd;
    logic        tv;
    logic [7:0]  td;
  } asfr_st_t;
  asfr_st_t s_q, s_d;
  logic f_in_ready, f_out_valid;
  logic [7:0] f_out_data;
  logic [7:0] hb;
  // frame builder may advance: no byte is waiting on a full buffer
  logic adv;
  assign adv = !(s_q.fv && !f_in_ready);

  asfr_fifo #(.W(8), .D(`ASFR_FIFO_DEPTH), .AW(`ASFR_FIFO_AW)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (s_q.fv),
    .in_ready  (f_in_ready),
    .in_data   (s_q.fd),
    .out_valid (f_out_valid),
    .out_ready (!s_q.tv || tx_ready),
    .out_data  (f_out_data)
  );

  always_comb begin
    case (s_q.hidx)
      3'h0: hb = s_q.b3;
      3'h1: hb = s_q.b4;
      3'h2: hb = s_q.b5;
      3'h3: hb = s_q.b6;
      default: hb = s_q.b7;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // latch events; they pend until their frame is started from idle
    if (send_done && send_fid != 8'h00 && !s_q.p_send) begin
      s_d.p_send   = 1'b1;
      s_d.p_send_w = {send_fid, send_status};
    end
    if (dsts_done && !s_q.p_dsts) begin
      s_d.p_dsts   = 1'b1;
      s_d.p_dsts_w = {dsts_fid, dsts_status};
    end
    if (ferr_event && !s_q.p_ferr) begin
      s_d.p_ferr   = 1'b1;
      s_d.p_ferr_c = ferr_cause;
    end
    s_d.rdy = 1'b0;
    if (s_q.fv && f_in_ready) s_d.fv = 1'b0;
    if (!s_d.fv) begin
      case (s_q.st)
        asfr_pkg::ST_IDLE: begin
          s_d.hidx = 3'h0;
          s_d.blen = 16'h0000;
          s_d.b6 = 8'h00;
          s_d.b7 = 8'h00;
          if (s_q.p_ferr) begin
            s_d.kind = asfr_pkg::K_FERR;
            s_d.b3 = `ASFR_T_FERR;
            s_d.b4 = s_q.p_ferr_c;
            s_d.hcnt = 3'h2;
            s_d.p_ferr = 1'b0;
            s_d.st = asfr_pkg::ST_DELIM;
          end else if (s_q.p_dsts) begin
            s_d.kind = asfr_pkg::K_DSTS;
            s_d.b3 = `ASFR_T_DEV_STS;
            s_d.b4 = s_q.p_dsts_w[15:8];
            s_d.b5 = s_q.p_dsts_w[7:0];
            s_d.hcnt = 3'h3;
            s_d.p_dsts = 1'b0;
            s_d.st = asfr_pkg::ST_DELIM;
          end else if (s_q.p_send) begin
            s_d.kind = asfr_pkg::K_SEND;
            s_d.b3 = `ASFR_T_SEND_RSP;
            s_d.b4 = s_q.p_send_w[15:8];
            s_d.b5 = s_q.p_send_w[7:0];
            s_d.hcnt = 3'h3;
            s_d.p_send = 1'b0;
            s_d.st = asfr_pkg::ST_DELIM;
          end else if (dreq_start) begin
            s_d.kind = asfr_pkg::K_DREQ;
            s_d.b3 = `ASFR_T_DEV_REQ;
            s_d.b4 = dreq_id;
            s_d.b5 = dreq_transport;
            s_d.b6 = dreq_flags;
            s_d.b7 = dreq_tlen;
            s_d.blen = dreq_blen;
            s_d.hcnt = 3'h5;
            s_d.st = asfr_pkg::ST_DELIM;
          end
          s_d.len = 16'({13'h0, s_d.hcnt}) + s_d.blen;
        end
        asfr_pkg::ST_DELIM: begin
          s_d.fv = 1'b1;
          s_d.fd = `ASFR_DELIM;
          s_d.sum = 8'h00;
          s_d.st = asfr_pkg::ST_LEN_HI;
        end
        asfr_pkg::ST_LEN_HI: begin
          s_d.fv = 1'b1;
          s_d.fd = s_q.len[15:8];
          s_d.st = asfr_pkg::ST_LEN_LO;
        end
        asfr_pkg::ST_LEN_LO: begin
          s_d.fv = 1'b1;
          s_d.fd = s_q.len[7:0];
          s_d.st = asfr_pkg::ST_HDR;
        end
        asfr_pkg::ST_HDR: begin
          s_d.fv = 1'b1;
          s_d.fd = hb;
          s_d.sum = s_q.sum + hb;
          s_d.hidx = s_q.hidx + 3'h1;
          if (s_q.hidx + 3'h1 == s_q.hcnt)
            s_d.st = (s_q.blen != 16'h0000) ? asfr_pkg::ST_BODY
                                            : asfr_pkg::ST_SUM;
        end
        asfr_pkg::ST_BODY: begin
          if (dreq_valid && !s_q.rdy) begin
            s_d.rdy = 1'b1;
            s_d.fv = 1'b1;
            s_d.fd = dreq_data;
            s_d.sum = s_q.sum + dreq_data;
            s_d.blen = s_q.blen - 16'h0001;
            if (s_q.blen == 16'h0001) s_d.st = asfr_pkg::ST_SUM;
          end
        end
        asfr_pkg::ST_SUM: begin
          s_d.fv = 1'b1;
          s_d.fd = 8'hff - s_q.sum;
          s_d.st = asfr_pkg::ST_IDLE;
        end
        default: s_d.st = asfr_pkg::ST_IDLE;
      endcase
    end
    if (!s_q.tv || tx_ready) begin
      s_d.tv = f_out_valid;
      s_d.td = f_out_data;
    end
    s_d.busy = s_d.p_send || s_d.p_dsts || s_d.p_ferr;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= asfr_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt_busy   = s_q.busy;
  assign dreq_ready = s_q.rdy;
  assign tx_valid   = s_q.tv;
  assign tx_data    = s_q.td;

  // event capture

  chk_send_zero_id: assert property (@(posedge clk) disable iff (rst)
    send_done && send_fid == 8'h00 && !s_q.p_send |=> !s_q.p_send)
    else $error("send response queued for zero frame id");

  chk_send_latch: assert property (@(posedge clk) disable iff (rst)
    send_done && send_fid != 8'h00 && !s_q.p_send |=> s_q.p_send)
    else $error("send completion not latched");

  chk_dsts_latch: assert property (@(posedge clk) disable iff (rst)
    dsts_done && !s_q.p_dsts |=> s_q.p_dsts)
    else $error("response status event not latched");

  chk_ferr_latch: assert property (@(posedge clk) disable iff (rst)
    ferr_event && !s_q.p_ferr |=> s_q.p_ferr)
    else $error("frame error event not latched");

  // framing

  chk_delim_first: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_DELIM && adv |=> s_q.fd == `ASFR_DELIM)
    else $error("frame did not open with delimiter");

  chk_len_hi: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_LEN_HI && adv
    |=> s_q.fd == $past(s_q.len[15:8]))
    else $error("length high byte wrong");

  chk_len_lo: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_LEN_LO && adv
    |=> s_q.fd == $past(s_q.len[7:0]))
    else $error("length low byte wrong");

  chk_hdr_sum: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_HDR && adv
    |=> s_q.sum == $past(s_q.sum) + $past(hb))
    else $error("running sum wrong");

  chk_sum_value: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_SUM && adv |=> s_q.fd == 8'hff - $past(s_q.sum))
    else $error("checksum byte wrong");

  chk_tx_hold: assert property (@(posedge clk) disable iff (rst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("output byte dropped before ready");

  // frame selection

  chk_dsts_echo: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_IDLE && adv && !s_q.p_ferr && s_q.p_dsts
    |=> s_q.b4 == $past(s_q.p_dsts_w[15:8]) && s_q.b3 == `ASFR_T_DEV_STS)
    else $error("status frame id not echoed");

  chk_dsts_code: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_IDLE && adv && !s_q.p_ferr && s_q.p_dsts
    |=> s_q.b5 == $past(s_q.p_dsts_w[7:0]))
    else $error("status frame code not carried");

  chk_ferr_prio: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_IDLE && adv && s_q.p_ferr
    |=> s_q.b3 == `ASFR_T_FERR && s_q.hcnt == 3'h2 && !s_q.p_ferr)
    else $error("error report not started");

  chk_ferr_cause: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_IDLE && adv && s_q.p_ferr
    |=> s_q.b4 == $past(s_q.p_ferr_c))
    else $error("error cause not carried");

  chk_send_echo: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_IDLE && adv && !s_q.p_ferr && !s_q.p_dsts
    && s_q.p_send
    |=> s_q.b4 == $past(s_q.p_send_w[15:8])
    && s_q.b5 == $past(s_q.p_send_w[7:0]))
    else $error("send response fields not carried");

  chk_dreq_hdr: assert property (@(posedge clk) disable iff (rst)
    s_q.st == asfr_pkg::ST_IDLE && adv && !s_q.p_ferr && !s_q.p_dsts
    && !s_q.p_send && dreq_start
    |=> s_q.b4 == $past(dreq_id) && s_q.b7 == $past(dreq_tlen))
    else $error("device request header not captured");

  chk_dreq_type: assert property (@(posedge clk) disable iff (rst)
    s_q.kind == asfr_pkg::K_DREQ && s_q.st == asfr_pkg::ST_HDR
    |-> s_q.b3 == `ASFR_T_DEV_REQ && s_q.hcnt == 3'h5)
    else $error("device request header wrong");

  chk_dsts_type: assert property (@(posedge clk) disable iff (rst)
    s_q.kind == asfr_pkg::K_DSTS && s_q.st == asfr_pkg::ST_HDR
    |-> s_q.b3 == `ASFR_T_DEV_STS && s_q.hcnt == 3'h3)
    else $error("status frame header wrong");

  chk_ferr_len: assert property (@(posedge clk) disable iff (rst)
    s_q.kind == asfr_pkg::K_FERR && s_q.st == asfr_pkg::ST_LEN_HI
    |-> s_q.len == 16'h0002)
    else $error("error report length wrong");

  chk_rdy_pulse: assert property (@(posedge clk) disable iff (rst)
    s_q.rdy |=> !s_q.rdy)
    else $error("payload taken on back to back cycles");

  // header layout
  chk_send_type: assert property (@(posedge clk) disable iff (rst)
    s_q.kind == asfr_pkg::K_SEND && s_q.st == asfr_pkg::ST_HDR
    |-> s_q.b3 == `ASFR_T_SEND_RSP && s_q.hcnt == 3'h3)
    else $error("send response header wrong");
  chk_dreq_len: assert property (@(posedge clk) disable iff (rst)
    s_q.kind == asfr_pkg::K_DREQ && s_q.st == asfr_pkg::ST_LEN_HI
    |-> s_q.len == s_q.blen + 16'h0005)
    else $error("device request length wrong");
  chk_body_ready: assert property (@(posedge clk) disable iff (rst)
    s_q.rdy |-> $past(s_q.st) == asfr_pkg::ST_BODY)
    else $error("payload taken outside body");
endmodule

// ===== asfr_top_tb_top.sv
`timescale 1ns/1ns
module asfr_top_tb_top;
  logic clk, rst, send_done, dsts_done, ferr_event, dreq_start, dreq_valid;
  logic [7:0] send_fid, send_status, dsts_fid, dsts_status, ferr_cause;
  logic [7:0] dreq_id, dreq_transport, dreq_flags, dreq_tlen, dreq_data;
  logic [15:0] dreq_blen;
  logic evt_busy, dreq_ready, tx_valid, tx_ready;
  logic [7:0] tx_data;
  logic [1:0] pace;
  int bad_count, n_checks;

  asfr_top DUT (.clk(clk), .rst(rst), .send_done(send_done),
    .send_fid(send_fid), .send_status(send_status), .dsts_done(dsts_done),
    .dsts_fid(dsts_fid), .dsts_status(dsts_status),
    .ferr_event(ferr_event), .ferr_cause(ferr_cause),
    .dreq_start(dreq_start), .dreq_id(dreq_id),
    .dreq_transport(dreq_transport), .dreq_flags(dreq_flags),
    .dreq_tlen(dreq_tlen), .dreq_blen(dreq_blen), .dreq_valid(dreq_valid),
    .dreq_data(dreq_data), .evt_busy(evt_busy), .dreq_ready(dreq_ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  asfr_host_model HOST (.clk(clk), .rst(rst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .pace(pace));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task final_report();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  // waits for one whole frame and compares it byte by byte
  task chk_frame(input logic [7:0] body[$]);
    logic [7:0] e[$];
    logic [7:0] s;
    int n;
    s = 8'h00;
    e = {8'h7e, 8'h00, 8'(body.size())};
    for (n = 0; n < body.size(); n++) begin
      e.push_back(body[n]);
      s += body[n];
    end
    e.push_back(8'hff - s);
    for (n = 0; n < 3000 && HOST.got.size() < e.size(); n++) @(posedge clk);
    check(8'(HOST.got.size() >= e.size()), 8'h01);
    for (n = 0; n < e.size() && HOST.got.size() > 0; n++) begin
      check(HOST.got.pop_front(), e[n]);
    end
  endtask

  // m: bit0 send done, bit1 response status, bit2 frame error (cause f)
  task ev(input logic [2:0] m, input logic [7:0] f, input logic [7:0] s);
    @(negedge clk);
    {ferr_event, dsts_done, send_done} = m;
    {send_fid, send_status, dsts_fid, dsts_status} = {f, s, f, s};
    ferr_cause = f;
    @(negedge clk);
    {ferr_event, dsts_done, send_done} = 3'h0;
  endtask

  task t_send();
    logic [7:0] c[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40};
    for (int k = 0; k < 5; k++) begin
      pace = 2'(k & 1);
      ev(3'h1, 8'h55 + 8'(k), c[k]);
      check(8'(evt_busy), 8'h01);
      chk_frame({8'hb8, 8'h55 + 8'(k), c[k]});
    end
    ev(3'h1, 8'h00, 8'h00);
    repeat (80) @(posedge clk);
    check(8'(HOST.got.size()), 8'h00);
  endtask

  task t_dsts();
    logic [7:0] c[4] = '{8'h00, 8'h20, 8'h21, 8'h40};
    for (int k = 0; k < 4; k++) begin
      ev(3'h2, 8'h01 + 8'(k), c[k]);
      chk_frame({8'hba, 8'h01 + 8'(k), c[k]});
    end
  endtask

  task t_ferr();
    for (int k = 2; k < 9; k++) begin
      ev(3'h4, 8'(k), 8'h00);
      chk_frame({8'hfe, 8'(k)});
    end
    ev(3'h6, 8'h07, 8'h00);
    chk_frame({8'hfe, 8'h07});
    chk_frame({8'hba, 8'h07, 8'h00});
  endtask

  // host stalled for the first 200 cycles so the buffer fills, then drained every other cycle
  task t_dreq();
    logic [7:0] e[$];
    int k, n;
    e = {8'hb9, 8'h01, 8'h00, 8'h00, 8'h04};
    pace = 2'h2;
    @(negedge clk);
    {dreq_id, dreq_transport, dreq_flags, dreq_tlen} = 32'h01000004;
    dreq_blen = 16'h001e;
    dreq_start = 1'b1;
    dreq_valid = 1'b1;
    dreq_data = 8'h30;
    k = 0;
    for (n = 0; n < 2000 && k < 30; n++) begin
      @(negedge clk);
      if (n == 200) pace = 2'h1;
      if (dreq_ready === 1'b1) begin
        dreq_start = 1'b0;
        e.push_back(dreq_data);
        k++;
        dreq_data = 8'h30 + 8'(k);
        dreq_valid = (k < 30);
      end
    end
    chk_frame(e);
    pace = 2'h0;
  endtask

  initial begin
    {clk, rst, send_done, dsts_done, ferr_event, dreq_start, dreq_valid} = 7'h20;
    {send_fid, send_status, dsts_fid, dsts_status, ferr_cause} = 40'h0;
    {dreq_id, dreq_transport, dreq_flags, dreq_tlen, dreq_data} = 40'h0;
    dreq_blen = 16'h0000;
    pace = 2'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_send();
    t_dsts();
    t_ferr();
    t_dreq();
    final_report();
  end

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
